// *** logic/msrb_device.sv ***
// Slave end: serial frame decoder, local registers and internal access engine.
`timescale 1ns/1ps
`include "msrb_consts.svh"
module msrb_device #(
  parameter int ACC_CYC = `MSRB_ACC_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  msrb_if.device           link,
  input  wire logic        phy_address_select_pin,
  input  wire logic        boot_config_straps,
  output logic             pins_taken_over,
  output logic             csr_req,
  output logic             csr_write,
  output logic [31:0]      csr_addr,
  output logic [31:0]      csr_wdata,
  input  wire logic        csr_ack,
  input  wire logic        csr_err,
  input  wire logic [31:0] csr_rdata
);
  // =====================================================================
  // Declarations.
  logic [2:0]             mdc_s;
  logic [1:0]             mdio_s;
  logic [1:0]             sel_s;
  logic [1:0]             strap_s;
  logic [1:0]             cap_cnt;
  logic                   slave_mode;
  logic                   rise;
  logic                   bit_in;
  msrb_pkg::msrb_dev_state_t st;
  logic [5:0]             ones;
  logic [4:0]             cnt;
  logic [15:0]            sh;
  logic                   dout;
  logic                   oe_n;
  logic                   fr_wr;
  logic                   fr_rd;
  logic [4:0]             fr_reg;
  logic [4:0]             hdr_reg;
  logic [4:0]             hdr_phy;
  logic [1:0]             hdr_op;
  logic [4:0]             my_phy;
  logic                   hdr_ok;
  logic [15:0]            rd_val;
  logic [15:0]            addr_lo;
  logic [15:0]            addr_hi;
  logic [15:0]            data_lo;
  logic [15:0]            data_hi;
  logic                   busy;
  logic                   busy_rd;
  logic                   err;
  logic                   rd_err;
  logic                   incr;
  logic [15:0]            tmo;
  logic                   launch;
  logic                   done;
  logic                   fail;

  // =====================================================================
  // Pin synchronisers; only the second stage and later are read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdc_s   <= 3'h0;
      mdio_s  <= 2'h3;
      sel_s   <= 2'h0;
      strap_s <= 2'h0;
    end else begin
      mdc_s   <= {mdc_s[1:0], link.mdc};
      mdio_s  <= {mdio_s[0], link.mdio};
      sel_s   <= {sel_s[0], phy_address_select_pin};
      strap_s <= {strap_s[0], boot_config_straps};
    end
  end

  // Detects a clock rise; the data stage has the same depth as the clock stage so it shows the value at the rise.
  assign rise   = mdc_s[1] & ~mdc_s[2];
  assign bit_in = mdio_s[1];

  // Catches the slave strap once the synchroniser has filled after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_cnt    <= 2'h0;
      slave_mode <= 1'b0;
    end else begin
      if (cap_cnt != 2'h3) begin
        cap_cnt <= cap_cnt + 2'h1;
      end
      if (cap_cnt == 2'h2) begin
        slave_mode <= strap_s[1];
      end
    end
  end

  assign pins_taken_over = slave_mode;

  // =====================================================================
  // Header decode of the thirteen bits after the start zero.
  assign hdr_op  = sh[10:9];
  assign hdr_phy = sh[8:4];
  assign hdr_reg = {sh[3:0], bit_in};
  assign my_phy  = sel_s[1] ? `MSRB_PHY_HIGH : `MSRB_PHY_LOW;
  assign hdr_ok  = sh[11] && (hdr_op == `MSRB_OP_RD || hdr_op == `MSRB_OP_WR) &&
                   (hdr_phy == my_phy) && (hdr_reg <= `MSRB_R_STATUS);

  // Read value of the addressed local register, frozen at header time.
  always_comb begin
    rd_val = 16'h0000;
    if (hdr_reg == `MSRB_R_ADDR_LO) begin
      rd_val = addr_lo;
    end else if (hdr_reg == `MSRB_R_ADDR_HI) begin
      rd_val = addr_hi;
    end else if (hdr_reg == `MSRB_R_DATA_LO) begin
      rd_val = rd_err ? `MSRB_ERR_HALF : data_lo;
    end else if (hdr_reg == `MSRB_R_DATA_HI || hdr_reg == `MSRB_R_DATA_INC) begin
      rd_val = (busy || rd_err) ? `MSRB_ERR_HALF : data_hi;
    end else if (hdr_reg == `MSRB_R_DATA_PAS) begin
      rd_val = rd_err ? `MSRB_ERR_HALF : data_hi;
    end else if (hdr_reg == `MSRB_R_STATUS) begin
      rd_val = {13'h0000, err, busy_rd, busy};
    end
  end

  // =====================================================================
  // Frame state machine: preamble, header, turnaround and sixteen data bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st     <= msrb_pkg::d_idle;
      ones   <= 6'h00;
      cnt    <= 5'h00;
      sh     <= 16'h0000;
      dout   <= 1'b1;
      oe_n   <= 1'b1;
      fr_wr  <= 1'b0;
      fr_rd  <= 1'b0;
      fr_reg <= 5'h00;
    end else begin
      fr_wr <= 1'b0;
      fr_rd <= 1'b0;
      if (!slave_mode) begin
        st   <= msrb_pkg::d_idle;
        ones <= 6'h00;
        oe_n <= 1'b1;
      end else if (rise) begin
        case (st)
          msrb_pkg::d_idle: begin
            if (bit_in) begin
              ones <= (ones == `MSRB_PRE_ONES) ? ones : ones + 6'h01;
            end else begin
              if (ones == `MSRB_PRE_ONES) begin
                st  <= msrb_pkg::d_hdr;
                cnt <= 5'h00;
              end
              ones <= 6'h00;
            end
          end
          msrb_pkg::d_hdr: begin
            sh  <= {sh[14:0], bit_in};
            cnt <= cnt + 5'h01;
            if (cnt == `MSRB_HDR_LAST) begin
              cnt    <= 5'h00;
              fr_reg <= hdr_reg;
              if (!hdr_ok) begin
                st <= msrb_pkg::d_idle;
              end else if (hdr_op == `MSRB_OP_RD) begin
                st <= msrb_pkg::d_rta;
                sh <= rd_val;
              end else begin
                st <= msrb_pkg::d_wdat;
              end
            end
          end
          msrb_pkg::d_rta: begin
            oe_n <= 1'b0;
            dout <= 1'b0;
            st   <= msrb_pkg::d_rdat;
          end
          msrb_pkg::d_rdat: begin
            if (cnt == `MSRB_RD_LAST) begin
              oe_n  <= 1'b1;
              dout  <= 1'b1;
              st    <= msrb_pkg::d_idle;
              fr_rd <= 1'b1;
            end else begin
              dout <= sh[15];
              sh   <= {sh[14:0], 1'b0};
              cnt  <= cnt + 5'h01;
            end
          end
          msrb_pkg::d_wdat: begin
            sh  <= {sh[14:0], bit_in};
            cnt <= cnt + 5'h01;
            if (cnt == `MSRB_WR_LAST) begin
              st    <= msrb_pkg::d_idle;
              fr_wr <= 1'b1;
            end
          end
          default: begin
            st <= msrb_pkg::d_idle;
          end
        endcase
      end
    end
  end

  assign link.dev_mdio_o    = dout;
  assign link.dev_mdio_oe_n = oe_n;

  // =====================================================================
  // Internal access engine with a one microsecond guard.
  assign launch = (fr_wr || fr_rd) && !busy &&
                  (fr_reg == `MSRB_R_DATA_HI || fr_reg == `MSRB_R_DATA_INC);
  assign done   = busy && (csr_ack || tmo == 16'(ACC_CYC - 1));
  assign fail   = csr_err || !csr_ack;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy      <= 1'b0;
      csr_req   <= 1'b0;
      csr_write <= 1'b0;
      incr      <= 1'b0;
      err       <= 1'b0;
      rd_err    <= 1'b0;
      tmo       <= 16'h0000;
    end else if (launch) begin
      busy      <= 1'b1;
      csr_req   <= 1'b1;
      csr_write <= fr_wr;
      incr      <= (fr_reg == `MSRB_R_DATA_INC);
      err       <= 1'b0;
      rd_err    <= 1'b0;
      tmo       <= 16'h0000;
    end else if (busy) begin
      tmo <= tmo + 16'h0001;
      if (done) begin
        busy    <= 1'b0;
        csr_req <= 1'b0;
        if (fail) begin
          err    <= 1'b1;
          rd_err <= !csr_write;
        end
      end
    end
  end

  assign csr_addr  = {addr_hi, addr_lo};
  assign csr_wdata = {data_hi, data_lo};

  // =====================================================================
  // Local registers; completion of an access wins over a frame write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_lo <= 16'h0000;
      addr_hi <= 16'h0000;
      data_lo <= 16'h0000;
      data_hi <= 16'h0000;
      busy_rd <= 1'b0;
    end else begin
      if (fr_wr) begin
        if (fr_reg == `MSRB_R_ADDR_LO) begin
          addr_lo <= sh;
        end else if (fr_reg == `MSRB_R_ADDR_HI) begin
          addr_hi <= sh;
        end else if (fr_reg == `MSRB_R_DATA_LO) begin
          data_lo <= sh;
        end else if (fr_reg == `MSRB_R_DATA_PAS) begin
          data_hi <= sh;
        end else if ((fr_reg == `MSRB_R_DATA_HI || fr_reg == `MSRB_R_DATA_INC) && !busy) begin
          data_hi <= sh;
        end
      end
      if (fr_wr || fr_rd) begin
        busy_rd <= busy;
      end
      if (done && !fail && !csr_write) begin
        {data_hi, data_lo} <= csr_rdata;
      end
      if (done && !fail && incr) begin
        {addr_hi, addr_lo} <= {addr_hi, addr_lo} + 32'h0000_0001;
      end
    end
  end

endmodule : msrb_device

// *** logic/msrb_consts.svh ***
// Shared constants of the management serial register bridge.
// Operation
// - Data line sampled and changed on clock rise.
// - Select pin picks PHY address 0 or 31.
// - Frames follow the Clause 22 format.
// - Seven 16-bit local registers, addresses 0 to 6.
// - Registers 0 and 1 hold word address halves.
// - Register 2 is data low, 0x8888 on error.
// - Register 3 launches access, 0x8888 busy or error.
// - Register 4 launches, then increments address by one.
// - Register 5 is data high without launching.
// - Status bits: busy, busy at last, error.
// - Write: address, data low, data high launches.
// - Master masks byte address then shifts right two.
// - Read: data high read launches next read.
// - Slave strap takes over the shared pins.
// - Internal access finishes within one microsecond.
`ifndef MSRB_CONSTS_SVH
`define MSRB_CONSTS_SVH
// =====================================================================
// Local register addresses and values.
`define MSRB_R_ADDR_LO   5'h00
`define MSRB_R_ADDR_HI   5'h01
`define MSRB_R_DATA_LO   5'h02
`define MSRB_R_DATA_HI   5'h03
`define MSRB_R_DATA_INC  5'h04
`define MSRB_R_DATA_PAS  5'h05
`define MSRB_R_STATUS    5'h06
`define MSRB_ERR_HALF    16'h8888
`define MSRB_ST_BUSY     0
`define MSRB_ST_BUSY_RD  1
`define MSRB_ST_ERR      2
// =====================================================================
// Frame fields and positions.
`define MSRB_PHY_LOW     5'h00
`define MSRB_PHY_HIGH    5'h1F
`define MSRB_OP_RD       2'h2
`define MSRB_OP_WR       2'h1
`define MSRB_PRE_ONES    6'h20
`define MSRB_HDR_LAST    5'h0C
`define MSRB_RD_LAST     5'h10
`define MSRB_WR_LAST     5'h11
`define MSRB_BIT_TA      7'h2E
`define MSRB_BIT_RD0     7'h31
`define MSRB_BIT_END     7'h40
// =====================================================================
// Timing.
`define MSRB_CLK_NS      25
`define MSRB_ACC_NS      1000
`define MSRB_ACC_CYC     (`MSRB_ACC_NS / `MSRB_CLK_NS)
`define MSRB_MDC_HALF    3'h4
// =====================================================================
// Controller registers on the AHB-Lite side.
`define MSRB_A_CMD       8'h00
`define MSRB_A_WDATA     8'h04
`define MSRB_A_RDATA     8'h08
`define MSRB_A_STATUS    8'h0C
`define MSRB_A_INT_STAT  8'h10
`define MSRB_A_INT_MASK  8'h14
`define MSRB_CMD_GO      0
`define MSRB_CMD_RD      1
`define MSRB_CMD_PHY_LSB 8
`define MSRB_CMD_REG_LSB 16
`endif

// *** logic/msrb_pkg.sv ***
// Types of the management serial register bridge.
package msrb_pkg;
  // Slave frame states, Gray coded along the read path only.
  typedef enum logic [2:0] {
    d_idle = 3'h0,
    d_hdr  = 3'h1,
    d_rta  = 3'h3,
    d_rdat = 3'h2,
    d_wdat = 3'h5
  } msrb_dev_state_t;
endpackage : msrb_pkg

// *** logic/msrb_if.sv ***
// Management link between the controller and the slave bridge.
`timescale 1ns/1ps
interface msrb_if;
  logic mdc;
  logic host_mdio_o;
  logic host_mdio_oe_n;
  logic dev_mdio_o;
  logic dev_mdio_oe_n;
  logic mdio;

  // Resolves the shared data line, pulled high when nobody drives it.
  assign mdio = !host_mdio_oe_n ? host_mdio_o :
                (!dev_mdio_oe_n ? dev_mdio_o : 1'b1);

  modport host (output mdc, output host_mdio_o, output host_mdio_oe_n, input mdio);
  modport device (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe_n);
endinterface : msrb_if

// *** logic/msrb_host.sv ***
// Master end: AHB-Lite command registers and management frame generator.
`timescale 1ns/1ps
`include "msrb_consts.svh"
module msrb_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq,
  msrb_if.host             link
);
  // =====================================================================
  // Declarations.
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        accept;
  logic        wr_cmd;
  logic        start;
  logic        cmd_rd;
  logic [4:0]  cmd_phy;
  logic [4:0]  cmd_reg;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done_st;
  logic        done_mask;
  logic        done_ev;
  logic [1:0]  mdio_s;
  logic        run;
  logic [2:0]  div;
  logic        mdc;
  logic        rise_p;
  logic [6:0]  bitn;
  logic [63:0] frame;
  logic [15:0] rsh;
  logic        dout;
  logic        oe_n;
  logic [31:0] rd_mux;

  // =====================================================================
  // Bus slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel && htrans[1] && hready;
  assign wr_cmd    = dp_wr && (dp_addr == `MSRB_A_CMD);
  assign start     = wr_cmd && hwdata[`MSRB_CMD_GO] && !run;

  // Captures the address phase of a write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= accept && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Selects read data; unmapped offsets read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `MSRB_A_CMD) begin
      rd_mux = {11'h000, cmd_reg, 3'h0, cmd_phy, 6'h00, cmd_rd, 1'b0};
    end else if (haddr[7:0] == `MSRB_A_WDATA) begin
      rd_mux = {16'h0000, wdata};
    end else if (haddr[7:0] == `MSRB_A_RDATA) begin
      rd_mux = {16'h0000, rdata};
    end else if (haddr[7:0] == `MSRB_A_STATUS) begin
      rd_mux = {31'h0000_0000, run};
    end else if (haddr[7:0] == `MSRB_A_INT_STAT) begin
      rd_mux = {31'h0000_0000, done_st};
    end else if (haddr[7:0] == `MSRB_A_INT_MASK) begin
      rd_mux = {31'h0000_0000, done_mask};
    end
  end

  // Read data is registered at the address phase and stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Command and data registers; a command is refused while a frame runs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_rd    <= 1'b0;
      cmd_phy   <= 5'h00;
      cmd_reg   <= 5'h00;
      wdata     <= 16'h0000;
      done_mask <= 1'b0;
    end else begin
      if (wr_cmd && !run) begin
        cmd_rd  <= hwdata[`MSRB_CMD_RD];
        cmd_phy <= hwdata[`MSRB_CMD_PHY_LSB +: 5];
        cmd_reg <= hwdata[`MSRB_CMD_REG_LSB +: 5];
      end
      if (dp_wr && dp_addr == `MSRB_A_WDATA) begin
        wdata <= hwdata[15:0];
      end
      if (dp_wr && dp_addr == `MSRB_A_INT_MASK) begin
        done_mask <= hwdata[0];
      end
    end
  end

  // Sticky completion flag, cleared by writing one; a new event wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_st <= 1'b0;
    end else if (done_ev) begin
      done_st <= 1'b1;
    end else if (dp_wr && dp_addr == `MSRB_A_INT_STAT && hwdata[0]) begin
      done_st <= 1'b0;
    end
  end

  assign irq = done_st && done_mask;

  // =====================================================================
  // Link: data line synchroniser and frame generator.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdio_s <= 2'h3;
    end else begin
      mdio_s <= {mdio_s[0], link.mdio};
    end
  end

  assign done_ev = rise_p && (bitn == `MSRB_BIT_END);

  // Divides the clock into the link clock; bits change just after each rise.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run    <= 1'b0;
      div    <= 3'h0;
      mdc    <= 1'b0;
      rise_p <= 1'b0;
      bitn   <= 7'h00;
      frame  <= 64'h0000_0000_0000_0000;
      rsh    <= 16'h0000;
      rdata  <= 16'h0000;
      dout   <= 1'b1;
      oe_n   <= 1'b1;
    end else begin
      rise_p <= 1'b0;
      if (start) begin
        run   <= 1'b1;
        div   <= 3'h0;
        mdc   <= 1'b0;
        bitn  <= 7'h00;
        frame <= {32'hFFFF_FFFF, 2'h1,
                  hwdata[`MSRB_CMD_RD] ? `MSRB_OP_RD : `MSRB_OP_WR,
                  hwdata[`MSRB_CMD_PHY_LSB +: 5], hwdata[`MSRB_CMD_REG_LSB +: 5],
                  2'h2, wdata};
      end else if (run) begin
        if (div == `MSRB_MDC_HALF - 3'h1) begin
          div    <= 3'h0;
          mdc    <= ~mdc;
          rise_p <= ~mdc;
        end else begin
          div <= div + 3'h1;
        end
        if (rise_p) begin
          if (bitn >= `MSRB_BIT_RD0) begin
            rsh <= {rsh[14:0], mdio_s[1]};
          end
          if (bitn == `MSRB_BIT_END) begin
            run  <= 1'b0;
            mdc  <= 1'b0;
            oe_n <= 1'b1;
            dout <= 1'b1;
            if (cmd_rd) begin
              rdata <= {rsh[14:0], mdio_s[1]};
            end
          end else begin
            dout  <= frame[63];
            frame <= {frame[62:0], 1'b0};
            oe_n  <= cmd_rd && (bitn >= `MSRB_BIT_TA);
            bitn  <= bitn + 7'h01;
          end
        end
      end
    end
  end

  assign link.mdc            = mdc;
  assign link.host_mdio_o    = dout;
  assign link.host_mdio_oe_n = oe_n;

endmodule : msrb_host

// *** verif/msrb_link_asserts.sv ***
// Wire-level checks of the management link between the two ends.
`timescale 1ns/1ps
module msrb_link_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mdc,
  input wire logic host_mdio_o,
  input wire logic host_mdio_oe_n,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe_n,
  input wire logic mdio
);
  logic [6:0] rn;
  logic [4:0] dn;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // Counts link clock rises since the host began driving the frame.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rn <= 7'h00;
    else if ($fell(host_mdio_oe_n)) rn <= 7'h00;
    else if ($rose(mdc)) rn <= rn + 7'h01;
  end
  // Counts link clock rises while the slave holds the line.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dn <= 5'h00;
    else if (dev_mdio_oe_n) dn <= 5'h00;
    else if ($rose(mdc)) dn <= dn + 5'h01;
  end
  // ==========
  // Line ownership, sampling moments and frame fields.
  chk_no_contention: assert property (host_mdio_oe_n || dev_mdio_oe_n)
    else $error("both ends drive the data line");
  chk_rise_stable: assert property ($rose(mdc) |-> $stable(mdio))
    else $error("data line moved at a clock rise");
  chk_clock_low_half: assert property ($fell(mdc) |-> !mdc [*4])
    else $error("link clock low phase too short");
  chk_preamble_ones: assert property (($rose(mdc) && rn < 7'h20) |-> mdio)
    else $error("preamble bit not one");
  chk_start_bits: assert property (($rose(mdc) && rn[6:1] == 6'h10) |-> mdio == rn[0])
    else $error("start field wrong");
  chk_turnaround_bits: assert property (($rose(mdc) && rn[6:1] == 6'h17) |-> mdio != rn[0])
    else $error("turnaround field wrong");
  chk_slave_window: assert property (!dev_mdio_oe_n |-> rn >= 7'h2F)
    else $error("slave drove before turnaround");
  chk_slave_bit_count: assert property ($rose(dev_mdio_oe_n) |-> dn == 5'h11)
    else $error("slave drove a wrong number of bits");
  // Main scenarios seen on the wire.
  cov_read_frame: cover property ($rose(dev_mdio_oe_n));
  cov_write_frame: cover property ($rose(mdc) && rn == 7'h3F && !host_mdio_oe_n);
  cov_frame_start: cover property ($fell(host_mdio_oe_n));
endmodule : msrb_link_asserts

// *** verif/mdio_slave_register_bridge_tb.sv ***
// Bench joining the AHB-Lite host end to the slave bridge over the link.
`timescale 1ns/1ps
module mdio_slave_register_bridge_tb;
  logic        hclk, hresetn, hsel, hwrite, irq, hresp, hreadyout, took, sel_pin;
  logic        csr_req, csr_write, csr_ack, csr_err, lw, rsp_err;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  ph;
  logic [31:0] haddr, hwdata, hrdata, csr_addr, csr_wdata, csr_rdata, la, ld, rsp_data, x;
  int          fail_count, total_checks, acc_n, dly, wait_n, cyc;
  // ==========
  // The two ends, the link between them and its checker.
  msrb_if i_msrb_if ();
  msrb_host i_msrb_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .link(i_msrb_if.host));
  // The guard is stretched so a slow target can be seen busy across frames.
  msrb_device #(.ACC_CYC(2000)) i_msrb_device (.hclk(hclk), .hresetn(hresetn),
    .link(i_msrb_if.device), .phy_address_select_pin(sel_pin), .boot_config_straps(1'b1),
    .pins_taken_over(took), .csr_req(csr_req), .csr_write(csr_write), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_ack(csr_ack), .csr_err(csr_err), .csr_rdata(csr_rdata));
  msrb_link_asserts i_msrb_link_asserts (.hclk(hclk), .hresetn(hresetn),
    .mdc(i_msrb_if.mdc), .host_mdio_o(i_msrb_if.host_mdio_o),
    .host_mdio_oe_n(i_msrb_if.host_mdio_oe_n), .dev_mdio_o(i_msrb_if.dev_mdio_o),
    .dev_mdio_oe_n(i_msrb_if.dev_mdio_oe_n), .mdio(i_msrb_if.mdio));
  // ==========
  // Makes the 40 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Internal target: answers after dly cycles and records the access.
  always @(posedge hclk) begin
    csr_ack <= 1'b0;
    if (!hresetn) begin
      {csr_err, csr_rdata} <= 33'h0_0000_0000;
    end
    if (csr_req && !csr_ack) begin
      wait_n <= wait_n + 1;
      if (wait_n == dly) begin
        {csr_ack, csr_err, csr_rdata} <= {1'b1, rsp_err, rsp_data};
        {la, lw, ld} <= {csr_addr, csr_write, csr_wdata};
        acc_n <= acc_n + 1;
      end
    end else begin
      wait_n <= 0;
    end
  end
  // Cuts a hung run short.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end
  // ==========
  // Counts a comparison and reports a mismatch.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // One single-word AHB-Lite transfer; read data lands in x.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {htrans, hwrite, haddr} <= {2'h2, w, 24'h0, a};
    do @(posedge hclk); while (!hreadyout);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (!hreadyout);
    x = hrdata;
  endtask : ahb
  // Sends one management frame and fetches what it returned into x.
  task automatic mf(input logic rd, input logic [4:0] r, input logic [15:0] d);
    ahb(1'b1, 8'h04, {16'h0, d});
    ahb(1'b1, 8'h00, {11'h0, r, 3'h0, ph, 6'h0, rd, 1'b1});
    do ahb(1'b0, 8'h0C, 32'h0); while (x[0]);
    ahb(1'b0, 8'h08, 32'h0);
    repeat (8) @(posedge hclk); // Lets a launched internal access finish.
  endtask : mf
  // Reads a local register over the link and compares it.
  task automatic rc(input logic [4:0] r, input logic [15:0] e);
    mf(1'b1, r, 16'h0);
    cmp(x, {16'h0, e});
  endtask : rc
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // ==========
  // Resets both ends, then works through the scenarios.
  initial begin
    {hresetn, hsel, htrans, hwrite, sel_pin, rsp_err} = 7'h00;
    {haddr, hwdata, rsp_data} = 96'h0;
    hsize = 3'h2;
    ph = 5'h00;
    dly = 2;
    repeat (20) @(posedge hclk);
    {hresetn, hsel} <= 2'h3;
    repeat (4) @(posedge hclk);
    cmp({31'h0, took}, 32'h1);
    // Write: nothing starts until the high data half is written.
    mf(1'b0, 5'h00, 16'h5678);
    mf(1'b0, 5'h01, 16'h0012);
    mf(1'b0, 5'h02, 16'hBEEF);
    cmp(acc_n, 32'h0);
    mf(1'b0, 5'h03, 16'hCAFE);
    rc(5'h00, 16'h5678);
    cmp(la, 32'h00125678);
    cmp(ld, 32'hCAFEBEEF);
    cmp({31'h0, lw}, 32'h1);
    rc(5'h06, 16'h0000);
    $display("test write done");
    // Read: the high half launches, values come from the access before.
    rsp_data = 32'hA1B2C3D4;
    rc(5'h02, 16'hBEEF);
    rc(5'h03, 16'hCAFE);
    rc(5'h02, 16'hC3D4);
    cmp({31'h0, lw}, 32'h0);
    rc(5'h05, 16'hA1B2);
    cmp(acc_n, 32'h2);
    mf(1'b0, 5'h00, 16'hFFFF);
    rc(5'h04, 16'hA1B2);
    cmp(la, 32'h0012FFFF);
    rc(5'h00, 16'h0000);
    rc(5'h01, 16'h0013);
    $display("test read done");
    // Slow target: status and data high report the pending access.
    dly = 1200;
    mf(1'b1, 5'h03, 16'h0000);
    rc(5'h06, 16'h0001);
    rc(5'h03, 16'h8888);
    rc(5'h06, 16'h0002);
    cmp(acc_n, 32'h4);
    // Unanswered target: the guard ends the access as an error.
    dly = 3000;
    mf(1'b1, 5'h03, 16'h0000);
    repeat (2100) @(posedge hclk);
    rc(5'h06, 16'h0004);
    cmp(acc_n, 32'h4);
    dly = 2;
    $display("test busy done");
    // Failed read: error flag and the error pattern in every data half.
    rsp_err = 1'b1;
    mf(1'b1, 5'h03, 16'h0000);
    rc(5'h06, 16'h0004);
    rc(5'h02, 16'h8888);
    rc(5'h05, 16'h8888);
    rsp_err = 1'b0;
    rc(5'h03, 16'h8888);
    rc(5'h02, 16'hC3D4);
    $display("test error done");
    // Address select: only the selected PHY address is answered.
    ph = 5'h1F;
    mf(1'b0, 5'h00, 16'h0042);
    ph = 5'h00;
    rc(5'h00, 16'h0000);
    sel_pin <= 1'b1;
    ph = 5'h1F;
    mf(1'b0, 5'h00, 16'h0042);
    rc(5'h00, 16'h0042);
    $display("test address select done");
    // Interrupt: masked, unmasked, cleared; then an unmapped offset.
    ahb(1'b0, 8'h10, 32'h0);
    cmp({30'h0, x[0], irq}, 32'h2);
    ahb(1'b1, 8'h14, 32'h1);
    @(negedge hclk);
    cmp({31'h0, irq}, 32'h1);
    ahb(1'b1, 8'h10, 32'h1);
    @(negedge hclk);
    cmp({31'h0, irq}, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    cmp(x, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    $display("test interrupt done");
    close_out();
  end
endmodule : mdio_slave_register_bridge_tb
